// ---- pad_ctl_if.sv ----
/*
 carrier between the pin core and the pad register stage.
 assumes both ends sit in the same mclk domain.
*/
`timescale 1ns/100ps
`default_nettype none
interface pad_ctl_if #(parameter int N = 8);
   port_pin_pkg::pad_drive_t [N-1:0] drive_d;
   port_pin_pkg::pad_drive_t [N-1:0] drive_q;
   modport core (output drive_d, input drive_q);
   modport pad (input drive_d, output drive_q);
endinterface
`default_nettype wire

// ---- pad_stage.sv ----
/*
 registers the drive, enable and pull-up of a group of pins.
 assumes mclk and rst_n of the pin core.
*/
`timescale 1ns/100ps
`default_nettype none
module pad_stage #(parameter int N = 8)
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // pin drive
   pad_ctl_if.pad pads
);
   // pins come up undriven with no pull-up until the first edge
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         pads.drive_q <= '0;
      else
         pads.drive_q <= pads.drive_d;
   end
endmodule
`default_nettype wire

// ---- port_pin_defs.svh ----
/*
 offsets, reset values, field positions and codes of the pin function block.
 assumes inclusion by bare name from design files.
*/
`ifndef PORT_PIN_DEFS_SVH
`define PORT_PIN_DEFS_SVH
`define PP_ADDR_W 8
`define PP_DATA_W 16
`define OFS_PA_LOW_FUNC 8'h00
`define OFS_PB_DIR 8'h04
`define OFS_PB_HIGH_FUNC 8'h08
`define OFS_PB_LOW_FUNC 8'h0c
`define OFS_PA_LOW_PINS 8'h10
`define OFS_PB_DIR_ACTIVE 8'h14
`define RST_PA_LOW_FUNC 16'hff95
`define RST_PB_DIR 16'h0000
`define RST_PB_FUNC 16'h0000
`define PA_LOW_RSVD_MASK 16'haa00
`define POS_PIN7 14
`define POS_PIN6 12
`define POS_PIN5 10
`define POS_PIN4 8
`define POS_PIN3 6
`define POS_PIN2 4
`define POS_PIN1 2
`define POS_PIN0 0
`define PB_SERIAL_CLOCK_CH1_PIN 13
`define PB_SERIAL_CLOCK_CH0_PIN 12
`define PB_TIMER_PINS 16'h003f
`define PB_CODE_GPIO 2'b00
`define PB_CODE_TIMER 2'b10
`define PB_CODE_SCK 2'b10
`endif

// ---- port_pin_function_select.sv ----
/*
 function select and direction logic for port A pins 0..7 and port B pins 0..15.
 assumes a plain register port in the mclk domain, rst_n as power-on reset
 and peripheral signals synchronous to mclk.
*/
// The register addresses and strobed register access were chosen for this implementation.
// Functional notes
// - low port A function bits 15, 13, 11 and 9 read as one and writes there are expected to be one.
// - bit 14 makes port A pin 7 gpio at 0 and bus grant acknowledge at 1, reset 1.
// - bit 12 makes port A pin 6 gpio at 0 and read strobe at 1, reset 1.
// - bit 10 makes port A pin 5 gpio at 0 and upper write or lower byte strobe at 1, reset 1.
// - bit 8 makes port A pin 4 gpio at 0 and lower or single write strobe at 1, reset 1.
// - bits 7:6 give pin 3 gpio, chip select seven or wait input, 11 reserved, reset 10.
// - pin 3 pull-up is on only as wait input and only when the bus controller asks for it.
// - bits 5:4 give pin 2 gpio, chip select six or timer 0 compare B, reset 01.
// - bits 3:2 give pin 1 gpio, chip select five or row strobe, reset 01.
// - bits 1:0 give pin 0 gpio, chip select four or timer 0 compare A, reset 01.
// - port B direction has one bit per pin, one drives the pin and zero makes it input.
// - a port B direction bit counts only for gpio, timer pins of channels 2 to 4 and serial clocks.
// - port B direction clears on power-on reset only.
// - port B functions sit in a high register for pins 15..8 and a low one for pins 7..0.
// - both port B function registers clear on power-on reset only.
// - the low port A function register loads ff95 on power-on reset only.
`timescale 1ns/100ps
`default_nettype none
`include "port_pin_defs.svh"
module port_pin_function_select
(
   // clock and power-on reset
   input wire logic mclk,
   input wire logic rst_n,
   // register port
   input wire logic [`PP_ADDR_W-1:0] reg_addr,
   input wire logic [`PP_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [`PP_DATA_W-1:0] reg_rdata,
   // port A general i/o side
   input wire logic [7:0] pa_gpio_out,
   input wire logic [7:0] pa_gpio_dir,
   // bus controller signals
   input wire logic bus_grant_ack,
   input wire logic read_strobe,
   input wire logic high_byte_store_strobe,
   input wire logic low_byte_store_strobe,
   input wire logic chip_select_seven,
   input wire logic chip_select_six,
   input wire logic chip_select_five,
   input wire logic chip_select_four,
   input wire logic row_strobe,
   input wire logic wait_pullup_sel,
   output logic wait_in,
   // timer channel 0
   input wire logic timer0_cc_a_out,
   input wire logic timer0_cc_a_oe,
   input wire logic timer0_cc_b_out,
   input wire logic timer0_cc_b_oe,
   output logic timer0_cc_a_in,
   output logic timer0_cc_b_in,
   // port A pins 0..7
   input wire logic [7:0] pa_pin_in,
   output logic [7:0] pa_pin_out,
   output logic [7:0] pa_pin_oe,
   output logic [7:0] pa_pin_pu,
   // port B general i/o and peripheral side
   input wire logic [15:0] pb_gpio_out,
   input wire logic [15:0] pb_periph_out,
   input wire logic [15:0] pb_periph_oe,
   output logic [31:0] pb_func_sel,
   output logic [15:0] pb_dir_active,
   // port B pins 0..15
   output logic [15:0] pb_pin_out,
   output logic [15:0] pb_pin_oe
);
   logic [15:0] pa_func_q;
   logic [15:0] pb_dir_q;
   logic [15:0] pb_high_func_q;
   logic [15:0] pb_low_func_q;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;
   logic wait_in_q;
   logic tmr_a_in_q;
   logic tmr_b_in_q;
   logic [15:0] pb_dir_active_q;
   logic [31:0] pb_func_all;
   logic [15:0] pb_dir_en;
   logic [15:0] pa_func_rd;
   port_pin_pkg::pa_fn2_t pin3_fn;
   port_pin_pkg::pa_fn2_t pin2_fn;
   port_pin_pkg::pa_fn2_t pin1_fn;
   port_pin_pkg::pa_fn2_t pin0_fn;

   pad_ctl_if #(.N(8)) pa_pads ();
   pad_ctl_if #(.N(16)) pb_pads ();

   pad_stage #(.N(8)) u_pa_pads
   (
      .mclk(mclk),
      .rst_n(rst_n),
      .pads(pa_pads.pad)
   );

   pad_stage #(.N(16)) u_pb_pads
   (
      .mclk(mclk),
      .rst_n(rst_n),
      .pads(pb_pads.pad)
   );

   // register writes; rst_n is the power-on reset, manual reset,
   // standby and sleep never reach these flops
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         pa_func_q <= `RST_PA_LOW_FUNC;
      else if (reg_wr && reg_addr == `OFS_PA_LOW_FUNC)
         pa_func_q <= reg_wdata | `PA_LOW_RSVD_MASK;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         pb_dir_q <= `RST_PB_DIR;
      else if (reg_wr && reg_addr == `OFS_PB_DIR)
         pb_dir_q <= reg_wdata;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pb_high_func_q <= `RST_PB_FUNC;
         pb_low_func_q <= `RST_PB_FUNC;
      end
      else if (reg_wr)
      begin
         if (reg_addr == `OFS_PB_HIGH_FUNC)
            pb_high_func_q <= reg_wdata;
         if (reg_addr == `OFS_PB_LOW_FUNC)
            pb_low_func_q <= reg_wdata;
      end
   end

   // reserved bits are forced on read too, so a stray flop upset cannot show
   assign pa_func_rd = pa_func_q | `PA_LOW_RSVD_MASK;

   // read mux; unmapped offsets read zero
   always_comb
   begin
      rdata_d = 16'h0000;
      case (reg_addr)
         `OFS_PA_LOW_FUNC: rdata_d = pa_func_rd;
         `OFS_PB_DIR: rdata_d = pb_dir_q;
         `OFS_PB_HIGH_FUNC: rdata_d = pb_high_func_q;
         `OFS_PB_LOW_FUNC: rdata_d = pb_low_func_q;
         `OFS_PA_LOW_PINS: rdata_d = {8'h00, pa_pin_in};
         `OFS_PB_DIR_ACTIVE: rdata_d = pb_dir_active_q;
         default: rdata_d = 16'h0000;
      endcase
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         rdata_q <= 16'h0000;
      else if (reg_rd)
         rdata_q <= rdata_d;
      else
         rdata_q <= 16'h0000;
   end

   // field decode; a reserved code falls back to gpio
   always_comb
   begin
      pin3_fn = port_pin_pkg::pa_fn2_t'(pa_func_q[`POS_PIN3 +: 2]);
      pin2_fn = port_pin_pkg::pa_fn2_t'(pa_func_q[`POS_PIN2 +: 2]);
      pin1_fn = port_pin_pkg::pa_fn2_t'(pa_func_q[`POS_PIN1 +: 2]);
      pin0_fn = port_pin_pkg::pa_fn2_t'(pa_func_q[`POS_PIN0 +: 2]);
      if (pin3_fn == port_pin_pkg::fn2_reserved)
         pin3_fn = port_pin_pkg::fn2_gpio;
      if (pin2_fn == port_pin_pkg::fn2_reserved)
         pin2_fn = port_pin_pkg::fn2_gpio;
      if (pin1_fn == port_pin_pkg::fn2_reserved)
         pin1_fn = port_pin_pkg::fn2_gpio;
      if (pin0_fn == port_pin_pkg::fn2_reserved)
         pin0_fn = port_pin_pkg::fn2_gpio;
   end

   // port A pins 7..4: one bit each, strobes are always driven
   always_comb
   begin
      pa_pads.drive_d = '0;
      for (int i = 4; i < 8; i++)
      begin
         pa_pads.drive_d[i].out = pa_gpio_out[i];
         pa_pads.drive_d[i].oe = pa_gpio_dir[i];
      end
      if (pa_func_q[`POS_PIN7])
      begin
         pa_pads.drive_d[7].out = bus_grant_ack;
         pa_pads.drive_d[7].oe = 1'b1;
      end
      if (pa_func_q[`POS_PIN6])
      begin
         pa_pads.drive_d[6].out = read_strobe;
         pa_pads.drive_d[6].oe = 1'b1;
      end
      if (pa_func_q[`POS_PIN5])
      begin
         pa_pads.drive_d[5].out = high_byte_store_strobe;
         pa_pads.drive_d[5].oe = 1'b1;
      end
      if (pa_func_q[`POS_PIN4])
      begin
         pa_pads.drive_d[4].out = low_byte_store_strobe;
         pa_pads.drive_d[4].oe = 1'b1;
      end
      // pin 3
      case (pin3_fn)
         port_pin_pkg::fn2_primary:
         begin
            pa_pads.drive_d[3].out = chip_select_seven;
            pa_pads.drive_d[3].oe = 1'b1;
         end
         port_pin_pkg::fn2_secondary:
         begin
            pa_pads.drive_d[3].out = 1'b0;
            pa_pads.drive_d[3].oe = 1'b0;
            pa_pads.drive_d[3].pu = wait_pullup_sel;
         end
         default:
         begin
            pa_pads.drive_d[3].out = pa_gpio_out[3];
            pa_pads.drive_d[3].oe = pa_gpio_dir[3];
         end
      endcase
      // pin 2
      case (pin2_fn)
         port_pin_pkg::fn2_primary:
         begin
            pa_pads.drive_d[2].out = chip_select_six;
            pa_pads.drive_d[2].oe = 1'b1;
         end
         port_pin_pkg::fn2_secondary:
         begin
            pa_pads.drive_d[2].out = timer0_cc_b_out;
            pa_pads.drive_d[2].oe = timer0_cc_b_oe;
         end
         default:
         begin
            pa_pads.drive_d[2].out = pa_gpio_out[2];
            pa_pads.drive_d[2].oe = pa_gpio_dir[2];
         end
      endcase
      // pin 1
      case (pin1_fn)
         port_pin_pkg::fn2_primary:
         begin
            pa_pads.drive_d[1].out = chip_select_five;
            pa_pads.drive_d[1].oe = 1'b1;
         end
         port_pin_pkg::fn2_secondary:
         begin
            pa_pads.drive_d[1].out = row_strobe;
            pa_pads.drive_d[1].oe = 1'b1;
         end
         default:
         begin
            pa_pads.drive_d[1].out = pa_gpio_out[1];
            pa_pads.drive_d[1].oe = pa_gpio_dir[1];
         end
      endcase
      // pin 0
      case (pin0_fn)
         port_pin_pkg::fn2_primary:
         begin
            pa_pads.drive_d[0].out = chip_select_four;
            pa_pads.drive_d[0].oe = 1'b1;
         end
         port_pin_pkg::fn2_secondary:
         begin
            pa_pads.drive_d[0].out = timer0_cc_a_out;
            pa_pads.drive_d[0].oe = timer0_cc_a_oe;
         end
         default:
         begin
            pa_pads.drive_d[0].out = pa_gpio_out[0];
            pa_pads.drive_d[0].oe = pa_gpio_dir[0];
         end
      endcase
   end

   // inputs towards peripherals; wait is active low, so it idles high
   // whenever the pin belongs to someone else
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wait_in_q <= 1'b1;
         tmr_a_in_q <= 1'b0;
         tmr_b_in_q <= 1'b0;
      end
      else
      begin
         wait_in_q <= (pin3_fn == port_pin_pkg::fn2_secondary) ? pa_pin_in[3] : 1'b1;
         tmr_b_in_q <= (pin2_fn == port_pin_pkg::fn2_secondary) & pa_pin_in[2];
         tmr_a_in_q <= (pin0_fn == port_pin_pkg::fn2_secondary) & pa_pin_in[0];
      end
   end

   assign pb_func_all = {pb_high_func_q, pb_low_func_q};

   // which port B pins obey their direction bit
   always_comb
   begin
      for (int i = 0; i < 16; i++)
      begin
         pb_dir_en[i] = (pb_func_all[2*i +: 2] == `PB_CODE_GPIO)
            || ((((`PB_TIMER_PINS >> i) & 16'h0001) != 16'h0000)
              && pb_func_all[2*i +: 2] == `PB_CODE_TIMER)
            || ((i == `PB_SERIAL_CLOCK_CH1_PIN || i == `PB_SERIAL_CLOCK_CH0_PIN)
              && pb_func_all[2*i +: 2] == `PB_CODE_SCK);
      end
   end

   // port B drive; other functions leave the enable to their peripheral
   always_comb
   begin
      pb_pads.drive_d = '0;
      for (int i = 0; i < 16; i++)
      begin
         if (pb_dir_en[i])
         begin
            pb_pads.drive_d[i].oe = pb_dir_q[i];
            pb_pads.drive_d[i].out = (pb_func_all[2*i +: 2] == `PB_CODE_GPIO) ?
               pb_gpio_out[i] : pb_periph_out[i];
         end
         else
         begin
            pb_pads.drive_d[i].oe = pb_periph_oe[i];
            pb_pads.drive_d[i].out = pb_periph_out[i];
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         pb_dir_active_q <= 16'h0000;
      else
         pb_dir_active_q <= pb_dir_en & pb_dir_q;
   end

   // outputs, each straight from a flop
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         pa_pin_out[i] = pa_pads.drive_q[i].out;
         pa_pin_oe[i] = pa_pads.drive_q[i].oe;
         pa_pin_pu[i] = pa_pads.drive_q[i].pu;
      end
      for (int i = 0; i < 16; i++)
      begin
         pb_pin_out[i] = pb_pads.drive_q[i].out;
         pb_pin_oe[i] = pb_pads.drive_q[i].oe;
      end
   end

   assign reg_rdata = rdata_q;
   assign wait_in = wait_in_q;
   assign timer0_cc_a_in = tmr_a_in_q;
   assign timer0_cc_b_in = tmr_b_in_q;
   assign pb_func_sel = pb_func_all;
   assign pb_dir_active = pb_dir_active_q;
endmodule
`default_nettype wire

// ---- port_pin_function_select_assertions.sv ----
/*
 checker for port A pin routing and low port A function readback.
 assumes binding into port_pin_function_select, one mclk domain, rst_n async.
*/
`timescale 1ns/100ps
`default_nettype none
`include "port_pin_defs.svh"
module port_pin_function_select_assertions
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // register port
   input wire logic [`PP_ADDR_W-1:0] reg_addr,
   input wire logic [`PP_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [`PP_DATA_W-1:0] reg_rdata,
   // peripheral side
   input wire logic bus_grant_ack,
   input wire logic read_strobe,
   input wire logic high_byte_store_strobe,
   input wire logic low_byte_store_strobe,
   input wire logic chip_select_four,
   input wire logic row_strobe,
   input wire logic wait_pullup_sel,
   input wire logic timer0_cc_b_out,
   input wire logic timer0_cc_b_oe,
   // port A pins
   input wire logic [7:0] pa_pin_out,
   input wire logic [7:0] pa_pin_oe,
   input wire logic [7:0] pa_pin_pu
);
   // shadow kept apart from the design so a stuck register shows up
   logic [15:0] fa_q;
   // pin stages still load their reset value on the edge that releases rst_n
   logic live_q;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n || !live_q);
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         live_q <= 1'b0;
      else
         live_q <= 1'b1;
   end
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         fa_q <= 16'hff95;
      else if (reg_wr && reg_addr == 8'h00)
         fa_q <= reg_wdata | 16'haa00;
   end
   a_rsvd_reads_one: assert property (reg_rd && reg_addr == 8'h00 |=> (reg_rdata & 16'haa00) == 16'haa00)
      else $error("reserved bits read back zero");
   a_func_readback: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == $past(fa_q))
      else $error("port A function readback wrong");
   a_grant_ack_routed: assert property (fa_q[14] |=> pa_pin_out[7] == $past(bus_grant_ack) && pa_pin_oe[7])
      else $error("pin 7 not bus grant acknowledge");
   a_read_strobe_routed: assert property (fa_q[12] |=> pa_pin_out[6] == $past(read_strobe) && pa_pin_oe[6])
      else $error("pin 6 not read strobe");
   a_upper_store_routed: assert property (fa_q[10] |=> pa_pin_out[5] == $past(high_byte_store_strobe))
      else $error("pin 5 not upper store strobe");
   a_lower_store_routed: assert property (fa_q[8] |=> pa_pin_out[4] == $past(low_byte_store_strobe))
      else $error("pin 4 not lower store strobe");
   a_wait_pin_input: assert property (fa_q[7:6] == 2'b10 |=> !pa_pin_oe[3] && pa_pin_pu[3] == $past(wait_pullup_sel))
      else $error("pin 3 wait input drive or pull-up wrong");
   a_no_pullup_else: assert property (fa_q[7:6] != 2'b10 |=> !pa_pin_pu[3])
      else $error("pin 3 pull-up on outside wait use");
   a_timer_b_routed: assert property (fa_q[5:4] == 2'b10 |=> pa_pin_out[2] == $past(timer0_cc_b_out)
      && pa_pin_oe[2] == $past(timer0_cc_b_oe))
      else $error("pin 2 not timer compare B");
   a_row_strobe_routed: assert property (fa_q[3:2] == 2'b10 |=> pa_pin_out[1] == $past(row_strobe) && pa_pin_oe[1])
      else $error("pin 1 not row strobe");
   a_cs_four_routed: assert property (fa_q[1:0] == 2'b01 |=> pa_pin_out[0] == $past(chip_select_four) && pa_pin_oe[0])
      else $error("pin 0 not chip select four");
endmodule
bind port_pin_function_select port_pin_function_select_assertions chk
(
   .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_grant_ack(bus_grant_ack), .read_strobe(read_strobe),
   .high_byte_store_strobe(high_byte_store_strobe), .low_byte_store_strobe(low_byte_store_strobe),
   .chip_select_four(chip_select_four), .row_strobe(row_strobe), .wait_pullup_sel(wait_pullup_sel),
   .timer0_cc_b_out(timer0_cc_b_out), .timer0_cc_b_oe(timer0_cc_b_oe), .pa_pin_out(pa_pin_out),
   .pa_pin_oe(pa_pin_oe), .pa_pin_pu(pa_pin_pu)
);
`default_nettype wire

// ---- port_pin_function_select_tb.sv ----
/*
 register and pin level bench for the pin function block.
 assumes the checker is bound beside it; drives every input itself.
*/
`timescale 1ns/100ps
`default_nettype none
module port_pin_function_select_tb;
   logic mclk, rst_n, reg_wr, reg_rd, wsel, wait_in, ta_out, ta_oe, tb_out, tb_oe, ta_in, tb_in, ras;
   logic [7:0] reg_addr, pa_gpio_out, pa_gpio_dir, pa_pin_in, pa_pin_out, pa_pin_oe, pa_pin_pu, pstb;
   logic [15:0] reg_wdata, reg_rdata, pb_gpio_out, pb_periph_out, pb_periph_oe, pb_dir_active, pb_pin_out, pb_pin_oe;
   logic [31:0] pb_func_sel;
   int fails, n_checks;
   port_pin_function_select uut
   (
      .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pa_gpio_out(pa_gpio_out), .pa_gpio_dir(pa_gpio_dir),
      .bus_grant_ack(pstb[7]), .read_strobe(pstb[6]), .high_byte_store_strobe(pstb[5]),
      .low_byte_store_strobe(pstb[4]), .chip_select_seven(pstb[3]), .chip_select_six(pstb[2]),
      .chip_select_five(pstb[1]), .chip_select_four(pstb[0]), .row_strobe(ras), .wait_pullup_sel(wsel),
      .wait_in(wait_in), .timer0_cc_a_out(ta_out), .timer0_cc_a_oe(ta_oe), .timer0_cc_b_out(tb_out),
      .timer0_cc_b_oe(tb_oe), .timer0_cc_a_in(ta_in), .timer0_cc_b_in(tb_in), .pa_pin_in(pa_pin_in),
      .pa_pin_out(pa_pin_out), .pa_pin_oe(pa_pin_oe), .pa_pin_pu(pa_pin_pu), .pb_gpio_out(pb_gpio_out),
      .pb_periph_out(pb_periph_out), .pb_periph_oe(pb_periph_oe), .pb_func_sel(pb_func_sel),
      .pb_dir_active(pb_dir_active), .pb_pin_out(pb_pin_out), .pb_pin_oe(pb_pin_oe)
   );
   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   // data stands only in the cycle after the strobe, so sample just past that edge
   task rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 chk(32'(reg_rdata), 32'(exp));
   endtask
   // pins follow a register write two edges later
   task settle;
      repeat (2) @(posedge mclk);
      #1;
   endtask
   task wrap_up;
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      repeat (3000) @(posedge mclk);
      fails++;
      wrap_up();
   end
   initial
   begin
      fails = 0;
      n_checks = 0;
      rst_n = 1'b0;
      {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      pstb = 8'ha2;
      wsel = 1'b1;
      pa_gpio_dir = 8'h5a;
      pa_gpio_out = 8'h3c;
      pa_pin_in = 8'h45;
      {ta_out, ta_oe, tb_out, tb_oe, ras} = 5'b11001;
      pb_gpio_out = 16'h1234;
      pb_periph_out = 16'hffff;
      pb_periph_oe = 16'h0000;
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      settle();
      rd(8'h00, 16'hff95);
      rd(8'h04, 16'h0000);
      rd(8'h08, 16'h0000);
      rd(8'h0c, 16'h0000);
      chk(32'(pa_pin_oe), 32'hf7);
      chk(32'(pa_pin_out & 8'hf7), 32'ha2);
      chk(32'(pa_pin_pu), 32'h08);
      chk(32'(wait_in), 32'h0);
      $display("reset test done");
      wr(8'h00, 16'h0000);
      settle();
      rd(8'h00, 16'haa00);
      chk(32'(pa_pin_oe), 32'h5a);
      chk(32'(pa_pin_out), 32'h3c);
      chk(32'(pa_pin_pu), 32'h00);
      chk(32'(wait_in), 32'h1);
      wr(8'h00, 16'h00aa);
      settle();
      rd(8'h00, 16'haaaa);
      chk(32'(pa_pin_oe), 32'h53);
      chk(32'(pa_pin_out & 8'hf7), 32'h33);
      chk(32'({ta_in, tb_in}), 32'h3);
      @(posedge mclk);
      wsel <= 1'b0;
      settle();
      chk(32'(pa_pin_pu), 32'h00);
      wr(8'h00, 16'h5555);
      settle();
      rd(8'h00, 16'hff55);
      chk(32'(pa_pin_oe), 32'hff);
      chk(32'(pa_pin_out), 32'ha2);
      wr(8'h00, 16'h00ff);
      settle();
      chk(32'(pa_pin_oe), 32'h5a);
      $display("port A test done");
      wr(8'h04, 16'hffff);
      wr(8'h08, 16'h0a00);
      wr(8'h0c, 16'h5aaa);
      settle();
      rd(8'h04, 16'hffff);
      rd(8'h08, 16'h0a00);
      rd(8'h0c, 16'h5aaa);
      rd(8'h14, 16'hff3f);
      chk(pb_func_sel, 32'h0a005aaa);
      chk(32'(pb_dir_active), 32'hff3f);
      chk(32'(pb_pin_oe), 32'hff3f);
      chk(32'(pb_pin_out & 16'hff3f), 32'h323f);
      wr(8'h04, 16'h0000);
      wr(8'h14, 16'hffff);
      settle();
      chk(32'(pb_pin_oe), 32'h0000);
      rd(8'h14, 16'h0000);
      rd(8'h20, 16'h0000);
      rd(8'h10, 16'h0045);
      $display("port B test done");
      wr(8'h04, 16'h00f0);
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      rd(8'h00, 16'hff95);
      rd(8'h04, 16'h0000);
      rd(8'h08, 16'h0000);
      rd(8'h0c, 16'h0000);
      $display("second reset test done");
      wrap_up();
   end
endmodule
`default_nettype wire

// ---- port_pin_pkg.sv ----
/*
 types shared by the pin function block.
 assumes nothing of its surroundings.
*/
package port_pin_pkg;
   typedef enum logic [1:0]
   {
      fn2_gpio = 2'b00,
      fn2_primary = 2'b01,
      fn2_secondary = 2'b10,
      fn2_reserved = 2'b11
   } pa_fn2_t;
   typedef struct packed
   {
      logic out;
      logic oe;
      logic pu;
   } pad_drive_t;
endpackage
